// File: hdl/iocd_decoder.sv
`timescale 1ns/1ps
// What this block does
// - Base select 00/01/10/11 picks pointer a, b, c, parameter block pointer.
// - Register field 000..111 picks a, b, c, count, task, index, control, mask.
// - Loading a 20-bit pointer through register field copies bit 15 upward.
// - Pointer field 000/001/010/100 addresses pointer a, b, c, task pointer.
// - In bit instructions the register field is a bit number, zero is LSB.
// - Literal size 01 means one byte follows, 10 means two bytes.
// - Displacement size 01 means one byte follows, 10 means two bytes.
// - Mode 00 uses the pointer; mode 01 adds unsigned offset, pointer unchanged.
// - Mode 10 adds the index register, both unchanged.
// - Mode 11 as 10, then index grows by one or two.
// - Width bit clear means byte operand, set means word operand.
// - Two base bytes then up to four extra bytes implied by fields.
// - Offsets unsigned; literals, displacements sign-extended; pointer load takes 32 bits.
// - Opcode is the second byte; first byte holds select, size, mode fields.
// - Bus sizes instruction sets source and destination widths, 1 means 16 bits.
// - Zero-second-byte controls: interrupt service, DMA transfer, bus sizes, no operation; halt uses second byte 48h.
// - Immediate pointer load takes four literal bytes into the chosen pointer.
// - Move immediate loads a register, sign-extending a byte literal.
// - Masked-compare jump branches by displacement when masked operand matches.
module iocd_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Instruction byte stream
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready_r,
   // Datapath register writes and memory operand
   input wire logic wr_en,
   input wire logic [2:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic ptr_wr_en,
   input wire logic [2:0] ptr_wr_sel,
   input wire logic [19:0] ptr_wr_data,
   input wire logic [19:0] parameter_block_pointer,
   input wire logic mem_valid,
   input wire logic [15:0] mem_data,
   // Decoded instruction
   output logic dec_valid_r,
   output logic invalid_r,
   output logic [7:0] opcode_r,
   output logic [2:0] register_select_field_r,
   output logic [15:0] bit_mask_r,
   output logic word_op_r,
   output logic [19:0] operand_addr_r,
   output logic [31:0] literal_r,
   output logic [15:0] disp_r,
   // Control events and state
   output logic halt_channel_r,
   output logic set_interrupt_service_r,
   output logic enter_dma_transfer_r,
   output logic src_wide_r,
   output logic dst_wide_r,
   output logic branch_taken_r,
   output logic branch_done_r,
   // Register file
   output logic [19:0] general_pointer_a,
   output logic [19:0] general_pointer_b,
   output logic [19:0] general_pointer_c,
   output logic [19:0] task_block_pointer,
   output logic [15:0] byte_count,
   output logic [15:0] index_register,
   output logic [15:0] channel_control,
   output logic [15:0] mask_compare
);
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic iocd_pkg::iocd_class_t op_class(input logic [7:0] op);
      casez (op)
         8'b1000_10??, 8'b1001_10??, 8'b1000_11??, 8'b1001_00??, 8'b1100_11??, 8'b1000_00??,
         8'b1000_01??, 8'b1110_1???, 8'b1101_????, 8'b1010_????, 8'b1111_01??, 8'b1111_10??,
         8'b1001_01??: op_class = iocd_pkg::CL_MEM;
         8'b0100_11??, 8'b1100_00??, 8'b1100_01??, 8'b1100_10??: op_class = iocd_pkg::CL_MEM_LIT;
         8'b1001_11??, 8'b1110_0???, 8'b1011_????: op_class = iocd_pkg::CL_MEM_DISP;
         8'h38, 8'h3C, 8'h2C: op_class = iocd_pkg::CL_REG;
         8'h30, 8'h20, 8'h24, 8'h28: op_class = iocd_pkg::CL_REG_LIT;
         8'h40, 8'h44: op_class = iocd_pkg::CL_REG_DISP;
         8'h08: op_class = iocd_pkg::CL_LOAD_POINTER_IMMEDIATE;
         8'h00, 8'h48: op_class = iocd_pkg::CL_CTRL;
         default: op_class = iocd_pkg::CL_BAD;
      endcase
   endfunction

   function automatic logic [2:0] size_bytes(input logic [1:0] sz);
      size_bytes = (sz == iocd_pkg::SZ_WORD) ? 3'h2 : (sz == iocd_pkg::SZ_BYTE) ? 3'h1 : 3'h0;
   endfunction

   // Pick 8 or 16 bits from the extra bytes and sign-extend to 16
   function automatic logic [15:0] pick_sx(input logic [7:0] xb [iocd_pkg::XB_N], input logic [1:0] idx,
         input logic [1:0] sz);
      pick_sx = (sz == iocd_pkg::SZ_WORD) ? {xb[2'(idx + 2'h1)], xb[idx]} : {{8{xb[idx][7]}}, xb[idx]};
   endfunction

   // ----------------------------------------
   // Fetch sequencing
   // ----------------------------------------
   iocd_pkg::iocd_state_t state_r, state_nxt;
   iocd_pkg::iocd_class_t cls_r;
   logic [7:0] b1_r;
   logic [7:0] xb_r [iocd_pkg::XB_N];
   logic [2:0] need_r, got_r, need_nxt;
   logic [19:0] regs_r [8];
   logic take;
   iocd_pkg::iocd_class_t cls_nxt;
   logic [1:0] mode, fsz;
   logic is_jump_masked_equal, bad;

   assign take = byte_valid && byte_ready_r;
   assign cls_nxt = iocd_pkg::iocd_class_t'(op_class(byte_data));
   assign mode = b1_r[2:1];
   assign fsz = b1_r[4:3];
   assign is_jump_masked_equal = opcode_r[7:2] == iocd_pkg::OP_JUMP_MASKED_EQUAL;

   always_comb begin
      need_nxt = 3'h0;
      case (cls_nxt)
         iocd_pkg::CL_MEM_LIT, iocd_pkg::CL_REG_LIT: need_nxt = size_bytes(fsz);
         iocd_pkg::CL_MEM_DISP, iocd_pkg::CL_REG_DISP: need_nxt = size_bytes(fsz);
         iocd_pkg::CL_LOAD_POINTER_IMMEDIATE: need_nxt = iocd_pkg::LOAD_POINTER_IMMEDIATE_BYTES;
         default: need_nxt = 3'h0;
      endcase
      if ((cls_nxt == iocd_pkg::CL_MEM || cls_nxt == iocd_pkg::CL_MEM_LIT || cls_nxt == iocd_pkg::CL_MEM_DISP)
            && mode == iocd_pkg::AA_OFS) begin
         need_nxt = 3'(need_nxt + 3'h1); // Offset byte comes first
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         iocd_pkg::ST_B1: if (take) state_nxt = iocd_pkg::ST_B2;
         iocd_pkg::ST_B2: if (take) state_nxt = (need_nxt == 3'h0) ? iocd_pkg::ST_DONE : iocd_pkg::ST_EXTRA;
         iocd_pkg::ST_EXTRA: if (take && got_r + 3'h1 == need_r) state_nxt = iocd_pkg::ST_DONE;
         iocd_pkg::ST_DONE: state_nxt = (is_jump_masked_equal && !bad) ? iocd_pkg::ST_MEM : iocd_pkg::ST_B1;
         iocd_pkg::ST_MEM: if (mem_valid) state_nxt = iocd_pkg::ST_B1;
         default: state_nxt = iocd_pkg::ST_B1;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= iocd_pkg::ST_B1;
         byte_ready_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         byte_ready_r <= state_nxt == iocd_pkg::ST_B1 || state_nxt == iocd_pkg::ST_B2 ||
            state_nxt == iocd_pkg::ST_EXTRA;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         b1_r <= 8'h00;
         opcode_r <= 8'h00;
         cls_r <= iocd_pkg::CL_BAD;
         need_r <= 3'h0;
         got_r <= 3'h0;
         for (int i = 0; i < iocd_pkg::XB_N; i++) xb_r[i] <= 8'h00;
      end else if (take) begin
         case (state_r)
            iocd_pkg::ST_B1: b1_r <= byte_data;
            iocd_pkg::ST_B2: begin
               opcode_r <= byte_data;
               cls_r <= cls_nxt;
               need_r <= need_nxt;
               got_r <= 3'h0;
            end
            iocd_pkg::ST_EXTRA: begin
               xb_r[got_r[1:0]] <= byte_data;
               got_r <= 3'(got_r + 3'h1);
            end
            default: got_r <= got_r;
         endcase
      end
   end

   // ----------------------------------------
   // Field extraction and validity
   // ----------------------------------------
   logic [1:0] ofs_n;
   logic [19:0] base, addr;
   logic [15:0] lit16, disp16;
   logic ptr_ok, ctrl_ok, has_lit, has_disp;

   assign has_lit = cls_r == iocd_pkg::CL_MEM_LIT || cls_r == iocd_pkg::CL_REG_LIT;
   assign has_disp = cls_r == iocd_pkg::CL_MEM_DISP || cls_r == iocd_pkg::CL_REG_DISP;
   assign ofs_n = (mode == iocd_pkg::AA_OFS && (cls_r == iocd_pkg::CL_MEM || has_lit || has_disp) &&
      cls_r != iocd_pkg::CL_REG_LIT && cls_r != iocd_pkg::CL_REG_DISP) ? 2'h1 : 2'h0;
   assign lit16 = pick_sx(xb_r, ofs_n, fsz);
   assign disp16 = pick_sx(xb_r, ofs_n, fsz);
   assign ptr_ok = b1_r[7:5] != 3'h3 && (!b1_r[7] || b1_r[6:5] == 2'h0);
   assign base = (opcode_r[1:0] == iocd_pkg::BASE_PP) ? parameter_block_pointer : regs_r[opcode_r[1:0]];

   always_comb begin
      case (mode)
         iocd_pkg::AA_PTR: addr = base;
         iocd_pkg::AA_OFS: addr = 20'(base + {12'h000, xb_r[0]});
         default: addr = 20'(base + {4'h0, regs_r[iocd_pkg::REG_IX][15:0]});
      endcase
   end

   always_comb begin
      ctrl_ok = 1'b0;
      if (opcode_r == iocd_pkg::OP_HALT) ctrl_ok = b1_r == iocd_pkg::B1_HALT;
      else if (opcode_r == iocd_pkg::OP_ZERO) ctrl_ok = b1_r == iocd_pkg::B1_NOP || b1_r == iocd_pkg::B1_SET_INTERRUPT_SERVICE ||
         b1_r == iocd_pkg::B1_ENTER_DMA_TRANSFER || (b1_r[7] && b1_r[4:0] == 5'h00);
      bad = cls_r == iocd_pkg::CL_BAD;
      if (cls_r == iocd_pkg::CL_CTRL) bad = !ctrl_ok;
      if (cls_r == iocd_pkg::CL_LOAD_POINTER_IMMEDIATE) bad = !ptr_ok || b1_r[3:0] != iocd_pkg::LOAD_POINTER_IMMEDIATE_LOW;
      if ((has_lit || has_disp) && (fsz == iocd_pkg::SZ_BAD || fsz == 2'h0)) bad = 1'b1;
      if (opcode_r[7:2] == iocd_pkg::OP_CALL && mode == iocd_pkg::AA_IDXINC) bad = 1'b1;
   end

   // ----------------------------------------
   // Decoded outputs
   // ----------------------------------------
   logic done;
   assign done = state_r == iocd_pkg::ST_DONE;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dec_valid_r <= 1'b0;
         invalid_r <= 1'b0;
         register_select_field_r <= 3'h0;
         bit_mask_r <= 16'h0000;
         word_op_r <= 1'b0;
         operand_addr_r <= 20'h00000;
         literal_r <= 32'h00000000;
         disp_r <= 16'h0000;
      end else begin
         dec_valid_r <= done && !bad;
         invalid_r <= done && bad;
         if (done) begin
            register_select_field_r <= b1_r[7:5];
            bit_mask_r <= 16'h0001 << b1_r[7:5];
            word_op_r <= b1_r[0];
            operand_addr_r <= addr;
            literal_r <= (cls_r == iocd_pkg::CL_LOAD_POINTER_IMMEDIATE) ? {xb_r[3], xb_r[2], xb_r[1], xb_r[0]} :
               {{16{lit16[15]}}, lit16};
            disp_r <= has_disp ? disp16 : 16'h0000;
         end
      end
   end

   // Control events are one-cycle pulses; bus widths are held levels
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         halt_channel_r <= 1'b0;
         set_interrupt_service_r <= 1'b0;
         enter_dma_transfer_r <= 1'b0;
         src_wide_r <= 1'b0;
         dst_wide_r <= 1'b0;
      end else begin
         halt_channel_r <= done && ctrl_ok && opcode_r == iocd_pkg::OP_HALT;
         set_interrupt_service_r <= done && ctrl_ok && opcode_r == iocd_pkg::OP_ZERO && b1_r == iocd_pkg::B1_SET_INTERRUPT_SERVICE;
         enter_dma_transfer_r <= done && ctrl_ok && opcode_r == iocd_pkg::OP_ZERO && b1_r == iocd_pkg::B1_ENTER_DMA_TRANSFER;
         if (done && ctrl_ok && opcode_r == iocd_pkg::OP_ZERO && b1_r[7]) begin
            src_wide_r <= b1_r[6];
            dst_wide_r <= b1_r[5];
         end
      end
   end

   // Masked compare: high byte of mask_compare is the mask, low byte the value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         branch_taken_r <= 1'b0;
         branch_done_r <= 1'b0;
      end else begin
         branch_done_r <= state_r == iocd_pkg::ST_MEM && mem_valid;
         branch_taken_r <= state_r == iocd_pkg::ST_MEM && mem_valid &&
            ((mem_data[7:0] ^ regs_r[iocd_pkg::REG_MC][7:0]) & regs_r[iocd_pkg::REG_MC][15:8]) == 8'h00;
      end
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   // Own writes land last so a committed instruction beats a datapath write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) regs_r[i] <= 20'h00000;
      end else begin
         if (ptr_wr_en) regs_r[ptr_wr_sel] <= ptr_wr_data;
         if (wr_en) regs_r[wr_sel] <= (wr_sel == iocd_pkg::REG_BC || wr_sel[2:1] == 2'h3 || wr_sel == iocd_pkg::REG_IX)
            ? {4'h0, wr_data} : {{4{wr_data[15]}}, wr_data};
         if (done && !bad && mode == iocd_pkg::AA_IDXINC && cls_r inside {iocd_pkg::CL_MEM,
               iocd_pkg::CL_MEM_LIT, iocd_pkg::CL_MEM_DISP}) begin
            regs_r[iocd_pkg::REG_IX] <= {4'h0, 16'(regs_r[iocd_pkg::REG_IX][15:0] + (b1_r[0] ? 16'h0002 : 16'h0001))};
         end
         if (done && !bad && cls_r == iocd_pkg::CL_LOAD_POINTER_IMMEDIATE) regs_r[b1_r[7:5]] <= {xb_r[2][3:0], xb_r[1], xb_r[0]};
         if (done && !bad && opcode_r == iocd_pkg::OP_MOVE_IMMEDIATE_R) regs_r[b1_r[7:5]] <=
            (b1_r[7:5] == iocd_pkg::REG_BC || b1_r[7:5] == iocd_pkg::REG_IX || b1_r[7:6] == 2'h3) ?
            {4'h0, lit16} : {{4{lit16[15]}}, lit16};
      end
   end

   assign general_pointer_a = regs_r[iocd_pkg::REG_GA];
   assign general_pointer_b = regs_r[iocd_pkg::REG_GB];
   assign general_pointer_c = regs_r[iocd_pkg::REG_GC];
   assign task_block_pointer = regs_r[iocd_pkg::REG_TP];
   assign byte_count = regs_r[iocd_pkg::REG_BC][15:0];
   assign index_register = regs_r[iocd_pkg::REG_IX][15:0];
   assign channel_control = regs_r[iocd_pkg::REG_CC][15:0];
   assign mask_compare = regs_r[iocd_pkg::REG_MC][15:0];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_call_mode_bad: assert property (done && opcode_r[7:2] == iocd_pkg::OP_CALL && mode == iocd_pkg::AA_IDXINC
      |=> invalid_r && !dec_valid_r) else $error("call with mode 11 not flagged");
   a_valid_excl: assert property (!(dec_valid_r && invalid_r)) else $error("valid and invalid together");
   a_mode0_addr: assert property (done && !bad && mode == iocd_pkg::AA_PTR |=> operand_addr_r == $past(base))
      else $error("mode 00 address wrong");
   a_ix_inc: assert property (done && !bad && mode == iocd_pkg::AA_IDXINC && cls_r == iocd_pkg::CL_MEM && !wr_en
      && !ptr_wr_en |=> index_register == 16'($past(index_register) + ($past(b1_r[0]) ? 16'h0002 : 16'h0001)))
      else $error("index post increment wrong");
   a_ix_hold: assert property (done && mode == iocd_pkg::AA_IDX && !wr_en && !ptr_wr_en |=> $stable(index_register))
      else $error("index changed in mode 10");
   a_halt_pulse: assert property (halt_channel_r |=> !halt_channel_r) else $error("halt not one pulse");
   a_sext_ptr: assert property (wr_en && wr_sel == iocd_pkg::REG_GA && !done && !ptr_wr_en |=>
      general_pointer_a[19:16] == {4{general_pointer_a[15]}}) else $error("pointer upper bits not sign");
   a_extra_max: assert property (state_r == iocd_pkg::ST_B2 && take |-> need_nxt <= 3'h4)
      else $error("too many extra bytes");
   a_done_one: assert property (done |=> state_r != iocd_pkg::ST_DONE) else $error("done held");
   a_bit_mask: assert property (dec_valid_r |-> bit_mask_r == 16'h0001 << register_select_field_r)
      else $error("bit mask wrong");

   c_mem_op: cover property (dec_valid_r && cls_r == iocd_pkg::CL_MEM);
   c_load_pointer_immediate: cover property (done && !bad && cls_r == iocd_pkg::CL_LOAD_POINTER_IMMEDIATE);
   c_branch: cover property (branch_taken_r);
   c_invalid: cover property (invalid_r);
endmodule

// File: hdl/iocd_pkg.sv
package iocd_pkg;
   // Register select codes
   localparam logic [2:0] REG_GA = 3'h0;
   localparam logic [2:0] REG_GB = 3'h1;
   localparam logic [2:0] REG_GC = 3'h2;
   localparam logic [2:0] REG_BC = 3'h3;
   localparam logic [2:0] REG_TP = 3'h4;
   localparam logic [2:0] REG_IX = 3'h5;
   localparam logic [2:0] REG_CC = 3'h6;
   localparam logic [2:0] REG_MC = 3'h7;
   localparam logic [1:0] BASE_PP = 2'h3;
   // Addressing modes and size codes
   localparam logic [1:0] AA_PTR = 2'h0;
   localparam logic [1:0] AA_OFS = 2'h1;
   localparam logic [1:0] AA_IDX = 2'h2;
   localparam logic [1:0] AA_IDXINC = 2'h3;
   localparam logic [1:0] SZ_BYTE = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   localparam logic [1:0] SZ_BAD = 2'h3;
   // Opcodes (second byte)
   localparam logic [7:0] OP_LOAD_POINTER_IMMEDIATE = 8'h08;
   localparam logic [7:0] OP_MOVE_IMMEDIATE_R = 8'h30;
   localparam logic [7:0] OP_HALT = 8'h48;
   localparam logic [7:0] OP_ZERO = 8'h00;
   localparam logic [5:0] OP_CALL = 6'h27;
   localparam logic [5:0] OP_JUMP_MASKED_EQUAL = 6'h2C;
   // Control first bytes
   localparam logic [7:0] B1_NOP = 8'h00;
   localparam logic [7:0] B1_HALT = 8'h20;
   localparam logic [7:0] B1_SET_INTERRUPT_SERVICE = 8'h40;
   localparam logic [7:0] B1_ENTER_DMA_TRANSFER = 8'h60;
   localparam logic [3:0] LOAD_POINTER_IMMEDIATE_LOW = 4'h1;
   localparam int PTR_W = 20;
   localparam int XB_N = 4;
   localparam logic [2:0] LOAD_POINTER_IMMEDIATE_BYTES = 3'h4;
   typedef enum {CL_BAD, CL_MEM, CL_MEM_LIT, CL_MEM_DISP, CL_REG, CL_REG_LIT, CL_REG_DISP,
      CL_LOAD_POINTER_IMMEDIATE, CL_CTRL} iocd_class_t;
   typedef enum {ST_B1, ST_B2, ST_EXTRA, ST_DONE, ST_MEM} iocd_state_t;
endpackage

// File: tb/iocd_decoder_tb.sv
`timescale 1ns/1ps
module iocd_decoder_tb;
   typedef struct packed {
      logic [47:0] bs;
      logic [2:0] n;
      logic inv;
      logic [3:0] pr;
      logic [31:0] ex;
   } iocd_row_t;
   // ----------------------------------------
   // Rows: bytes, count, invalid, probe, expected
   // ----------------------------------------
   localparam iocd_row_t ROWS [24] = '{
      '{48'h000000000000, 3'h2, 1'b0, 4'h9, 32'h0},
      '{48'h204800000000, 3'h2, 1'b0, 4'h9, 32'h4},
      '{48'h400000000000, 3'h2, 1'b0, 4'h9, 32'h2},
      '{48'h600000000000, 3'h2, 1'b0, 4'h9, 32'h1},
      '{48'hE00000000000, 3'h2, 1'b0, 4'h8, 32'h3},
      '{48'h800000000000, 3'h2, 1'b0, 4'h8, 32'h0},
      '{48'hA00000000000, 3'h2, 1'b0, 4'h8, 32'h1},
      '{48'h019800000000, 3'h2, 1'b0, 4'h1, 32'h10000},
      '{48'h0380F0000000, 3'h3, 1'b0, 4'h1, 32'h100F0},
      '{48'h018100000000, 3'h2, 1'b0, 4'h1, 32'h30000},
      '{48'h018300000000, 3'h2, 1'b0, 4'h1, 32'h20000},
      '{48'h058000000000, 3'h2, 1'b0, 4'h1, 32'h10004},
      '{48'h078000000000, 3'h2, 1'b0, 4'h1, 32'h10004},
      '{48'h068000000000, 3'h2, 1'b0, 4'h6, 32'h7},
      '{48'h693080000000, 3'h3, 1'b0, 4'h5, 32'hFF80},
      '{48'hB13034120000, 3'h4, 1'b0, 4'h6, 32'h1234},
      '{48'h093085000000, 3'h3, 1'b0, 4'h7, 32'hFFF85},
      '{48'h310878563412, 3'h6, 1'b0, 4'h2, 32'h12345678},
      '{48'h08BC02000000, 3'h3, 1'b0, 4'h4, 32'h1},
      '{48'hE8BC02000000, 3'h3, 1'b0, 4'h4, 32'h80},
      '{48'h084480000000, 3'h3, 1'b0, 4'h3, 32'hFF80},
      '{48'h104434120000, 3'h4, 1'b0, 4'h3, 32'h1234},
      '{48'h613000000000, 3'h2, 1'b1, 4'h0, 32'h0},
      '{48'h8E9C05000000, 3'h3, 1'b1, 4'h0, 32'h0}
   };
   logic clk, rstn, byte_valid, byte_ready_r, wr_en, ptr_wr_en, mem_valid;
   logic [7:0] byte_data, opcode_r;
   logic [2:0] wr_sel, ptr_wr_sel, register_select_field_r;
   logic [15:0] wr_data, mem_data, bit_mask_r, disp_r;
   logic [19:0] ptr_wr_data, parameter_block_pointer, operand_addr_r;
   logic dec_valid_r, invalid_r, word_op_r, halt_channel_r, set_interrupt_service_r;
   logic enter_dma_transfer_r, src_wide_r, dst_wide_r, branch_taken_r, branch_done_r;
   logic [31:0] literal_r;
   logic [19:0] general_pointer_a, general_pointer_b, general_pointer_c, task_block_pointer;
   logic [15:0] byte_count, index_register, channel_control, mask_compare;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;

   iocd_decoder dut (.clk(clk), .rstn(rstn), .byte_valid(byte_valid), .byte_data(byte_data),
      .byte_ready_r(byte_ready_r), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
      .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data),
      .parameter_block_pointer(parameter_block_pointer), .mem_valid(mem_valid), .mem_data(mem_data),
      .dec_valid_r(dec_valid_r), .invalid_r(invalid_r), .opcode_r(opcode_r),
      .register_select_field_r(register_select_field_r), .bit_mask_r(bit_mask_r), .word_op_r(word_op_r),
      .operand_addr_r(operand_addr_r), .literal_r(literal_r), .disp_r(disp_r),
      .halt_channel_r(halt_channel_r), .set_interrupt_service_r(set_interrupt_service_r),
      .enter_dma_transfer_r(enter_dma_transfer_r), .src_wide_r(src_wide_r), .dst_wide_r(dst_wide_r),
      .branch_taken_r(branch_taken_r), .branch_done_r(branch_done_r),
      .general_pointer_a(general_pointer_a), .general_pointer_b(general_pointer_b),
      .general_pointer_c(general_pointer_c), .task_block_pointer(task_block_pointer),
      .byte_count(byte_count), .index_register(index_register), .channel_control(channel_control),
      .mask_compare(mask_compare));

   iocd_fetch_model fm (.clk(clk), .rstn(rstn), .byte_ready_r(byte_ready_r), .byte_valid(byte_valid),
      .byte_data(byte_data), .mem_valid(mem_valid), .mem_data(mem_data));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wreg(input logic ptr, input logic [2:0] s, input logic [19:0] d);
      @(negedge clk);
      wr_en = !ptr;
      ptr_wr_en = ptr;
      wr_sel = s;
      ptr_wr_sel = s;
      wr_data = d[15:0];
      ptr_wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
      ptr_wr_en = 1'b0;
   endtask

   // Pulses are gathered over the whole wait, one cycle past the answer too
   task automatic run(input logic [47:0] bs, input logic [2:0] n, output logic [1:0] vi,
      output logic [2:0] pl);
      int w;
      vi = 2'b00;
      pl = 3'h0;
      w = 0;
      @(posedge clk);
      #1;
      for (int i = 0; i < n; i++) begin
         fm.push(bs[47 - 8 * i -: 8]);
      end
      while (vi == 2'b00 && w < 30) begin
         @(negedge clk);
         pl = pl | {halt_channel_r, set_interrupt_service_r, enter_dma_transfer_r};
         vi = {dec_valid_r, invalid_r};
         w++;
      end
      @(negedge clk);
      pl = pl | {halt_channel_r, set_interrupt_service_r, enter_dma_transfer_r};
   endtask

   function automatic logic [31:0] probe(input logic [3:0] p, input logic [2:0] pl);
      case (p)
         4'h1: probe = {12'h000, operand_addr_r};
         4'h2: probe = literal_r;
         4'h3: probe = {16'h0000, disp_r};
         4'h4: probe = {16'h0000, bit_mask_r};
         4'h5: probe = {16'h0000, byte_count};
         4'h6: probe = {16'h0000, index_register};
         4'h7: probe = {12'h000, general_pointer_a};
         4'h8: probe = {30'h0, src_wide_r, dst_wide_r};
         default: probe = {29'h0, pl};
      endcase
   endfunction

   initial begin
      logic [1:0] vi;
      logic [2:0] pl;
      int w;
      rstn = 1'b0;
      wr_en = 1'b0;
      ptr_wr_en = 1'b0;
      wr_sel = 3'h0;
      ptr_wr_sel = 3'h0;
      wr_data = 16'h0000;
      ptr_wr_data = 20'h00000;
      parameter_block_pointer = 20'h20000;
      repeat (6) @(negedge clk);
      check("ready_in_reset", {31'h0, byte_ready_r}, 32'h1);
      check("valid_in_reset", {31'h0, dec_valid_r}, 32'h0);
      rstn = 1'b1;
      wreg(1'b0, 3'h0, 20'h0F123);
      wreg(1'b0, 3'h4, 20'h08000);
      wreg(1'b0, 3'h6, 20'h0ABCD);
      wreg(1'b1, 3'h2, 20'h5A5A5);
      wreg(1'b0, 3'h7, 20'h0F05A);
      check("ga_sext", {12'h000, general_pointer_a}, 32'hFF123);
      check("tp_sext", {12'h000, task_block_pointer}, 32'hF8000);
      check("cc_load", {16'h0000, channel_control}, 32'hABCD);
      check("gc_load", {12'h000, general_pointer_c}, 32'h5A5A5);
      check("mc_load", {16'h0000, mask_compare}, 32'hF05A);
      wreg(1'b1, 3'h0, 20'h10000);
      wreg(1'b1, 3'h1, 20'h30000);
      wreg(1'b0, 3'h5, 20'h00004);
      for (int r = 0; r < 24; r++) begin
         run(ROWS[r].bs, ROWS[r].n, vi, pl);
         check("outcome", {30'h0, vi}, {30'h0, ~ROWS[r].inv, ROWS[r].inv});
         if (!ROWS[r].inv) begin
            check("opcode", {24'h0, opcode_r}, {24'h0, ROWS[r].bs[39:32]});
            check("fields", {28'h0, word_op_r, register_select_field_r},
               {28'h0, ROWS[r].bs[40], ROWS[r].bs[47:45]});
         end
         if (ROWS[r].pr != 4'h0) begin
            check("field", probe(ROWS[r].pr, pl), ROWS[r].ex);
         end
      end
      check("gb_load_pointer_immediate", {12'h000, general_pointer_b}, 32'h45678);
      // Back-to-back instructions with the stream never idling
      run(48'h204800000000, 3'h4, vi, pl);
      check("first_of_pair", {30'h0, vi}, 32'h2);
      run(48'h000000000000, 3'h0, vi, pl);
      check("second_of_pair", {30'h0, vi}, 32'h2);
      // Masked compare: low nibble differs but is masked off, then a real miss
      for (int k = 0; k < 2; k++) begin
         run(48'h08B0FE000000, 3'h3, vi, pl);
         repeat (4) @(negedge clk);
         fm.strobe(k == 0 ? 16'h0053 : 16'h0063);
         w = 0;
         while (branch_done_r !== 1'b1 && w < 10) begin
            @(negedge clk);
            w++;
         end
         check("branch_done", {31'h0, branch_done_r}, 32'h1);
         check("branch_taken", {31'h0, branch_taken_r}, {31'h0, k == 0});
         check("branch_disp", {16'h0000, disp_r}, 32'hFFFE);
      end
      // Mid-run reset returns widths and registers to zero
      @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      check("dst_wide_reset", {31'h0, dst_wide_r}, 32'h0);
      check("index_reset", {16'h0000, index_register}, 32'h0);
      check("ready_reset", {31'h0, byte_ready_r}, 32'h1);
      rstn = 1'b1;
      run(48'h000000000000, 3'h2, vi, pl);
      check("after_reset", {30'h0, vi}, 32'h2);
      end_sim();
   end
endmodule

// File: tb/iocd_fetch_model.sv
`timescale 1ns/1ps
module iocd_fetch_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Instruction byte stream
   input wire logic byte_ready_r,
   output logic byte_valid,
   output logic [7:0] byte_data,
   // Memory operand
   output logic mem_valid,
   output logic [15:0] mem_data
);
   logic [7:0] q[$];
   logic took;

   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
      mem_valid = 1'b0;
      mem_data = 16'h0000;
      took = 1'b0;
   end

   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask

   // One-cycle operand strobe; data goes stale right after
   task automatic strobe(input logic [15:0] d);
      @(negedge clk);
      mem_valid <= 1'b1;
      mem_data <= d;
      @(negedge clk);
      mem_valid <= 1'b0;
      mem_data <= ~d;
   endtask

   always @(posedge clk) begin
      took <= byte_valid && byte_ready_r;
   end

   // Bytes leave in program order and are held until taken
   // Idle data toggles so a stale byte never looks fresh
   always @(negedge clk) begin
      if (took && q.size() > 0) begin
         void'(q.pop_front());
      end
      if (q.size() > 0) begin
         byte_valid <= 1'b1;
         byte_data <= q[0];
      end else begin
         byte_valid <= 1'b0;
         byte_data <= ~byte_data;
      end
   end
endmodule
